// [sim/sram_properties.sv]
// checker: port-level properties of the status access mux
`timescale 1ns/1ps
module sram_properties (
  input wire logic clk, input wire logic rst_b, input wire sram_pkg::sram_phase_t phase,
  input wire sram_pkg::sram_uword_t microword, input wire logic forcedDispatch, input wire logic clearFlags,
  input wire logic busTransferInhibit_b, input wire logic [15:0] inputDataBusOut, input wire logic inputDataBusOe,
  input wire logic [15:0] processorStatusWord, input wire logic [11:0] currentMicroaddress,
  input wire logic [7:0] flagRegister, input wire logic literalDefaultSelect
);
  import sram_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [17:0] rt;
  wire [15:0] ps = processorStatusWord;
  // routing shadow; a clear-flags branch wins over a same-cycle load
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) rt <= '0;
    else if (clearFlags) rt <= '0;
    else if (phase == SRAM_PH_THREE && microword[24] && microword[23] && microword[20] && !microword[21])
      rt <= microword[47:30];
  wire rd1 = busTransferInhibit_b && !literalDefaultSelect && rt[6] && !rt[16] && rt[9:8] == 2'h1;
  property p_inh; !busTransferInhibit_b |-> !inputDataBusOe; endproperty
  a_inh: assert property (p_inh) else $error("inhibit");
  property p_lit; literalDefaultSelect && busTransferInhibit_b
    |-> inputDataBusOe && inputDataBusOut == {microword[47:44], microword[41:30]}; endproperty
  a_lit: assert property (p_lit) else $error("literal");
  property p_lds; clearFlags |=> literalDefaultSelect; endproperty
  a_lds: assert property (p_lds) else $error("default");
  property p_flg; clearFlags |=> flagRegister[3:0] == 4'h0 && $stable(flagRegister[7:4]); endproperty
  a_flg: assert property (p_flg) else $error("flags");
  property p_mode; ps[14] == ps[15] && ps[12] == ps[13]; endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_jam; forcedDispatch |=> $stable(currentMicroaddress); endproperty
  a_jam: assert property (p_jam) else $error("dispatch");
  property p_cua; phase != SRAM_PH_THREE |=> $stable(currentMicroaddress); endproperty
  a_cua: assert property (p_cua) else $error("phase");
  property p_rd1; rd1 |-> inputDataBusOe && inputDataBusOut == {{2{ps[15]}}, {2{ps[13]}}, 4'h0, ps[7:0]}; endproperty
  a_rd1: assert property (p_rd1) else $error("status");
  c_clr: cover property (clearFlags);
  c_jam: cover property (forcedDispatch);
  c_rd1: cover property (rd1);
endmodule : sram_properties
bind sram_status_access_mux sram_properties sram_properties_inst (.clk(clk), .rst_b(rst_b), .phase(phase),
  .microword(microword), .forcedDispatch(forcedDispatch), .clearFlags(clearFlags),
  .busTransferInhibit_b(busTransferInhibit_b), .inputDataBusOut(inputDataBusOut), .inputDataBusOe(inputDataBusOe),
  .processorStatusWord(processorStatusWord), .currentMicroaddress(currentMicroaddress),
  .flagRegister(flagRegister), .literalDefaultSelect(literalDefaultSelect));

// [sim/sram_seq_model.sv]
// microsequencer stand-in: phase ring and next microaddress
`timescale 1ns/1ps
module sram_seq_model (
  input wire logic clk,
  input wire logic rst_b,
  output sram_pkg::sram_phase_t phase,
  output logic [11:0] nextMicroaddress
);
  import sram_pkg::*;
  // address steps at phase four, so it is settled well before the next phase three
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= SRAM_PH_ONE;
      nextMicroaddress <= 12'h0;
    end else begin
      phase <= sram_phase_t'(phase + 2'h1);
      if (phase == SRAM_PH_FOUR) nextMicroaddress <= nextMicroaddress + 12'h1;
    end
  end
endmodule : sram_seq_model

// [sim/sram_status_access_mux_tb.sv]
// self-checking bench: microcycle tasks drive the status access mux
`timescale 1ns/1ps
module sram_status_access_mux_tb;
  import sram_pkg::*;
  sram_phase_t ph;
  sram_uword_t mw;
  logic clk, rst_b, fd, cf, inh_b, oe, lds, frl;
  logic [3:0] frc;
  logic [15:0] dOut, dIn, ps;
  logic [11:0] next_microaddress, current_microaddress, e;
  logic [7:0] fps, flg;
  int n_fail = 0;
  int checked = 0;
  sram_seq_model sram_seq_model_inst (.clk(clk), .rst_b(rst_b), .phase(ph), .nextMicroaddress(next_microaddress));
  sram_status_access_mux sram_status_access_mux_inst (.clk(clk), .rst_b(rst_b), .phase(ph), .microword(mw),
    .nextMicroaddress(next_microaddress), .forcedDispatch(fd), .clearFlags(cf), .busTransferInhibit_b(inh_b),
    .outputDataBus(dOut), .extensionFlags(2'h2), .fetchOverlapIndicator(1'b1), .fpResultCodes(frc),
    .fpResultLoad(frl), .inputDataBusOut(dIn), .inputDataBusOe(oe), .processorStatusWord(ps),
    .currentMicroaddress(current_microaddress), .fpStatusLow(fps), .flagRegister(flg), .literalDefaultSelect(lds));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one microcycle; microword and write data held through all four phases
  task automatic mc(input logic [17:0] rt, input logic [4:0] ctl, input logic [15:0] d);
    while (ph !== SRAM_PH_ONE) @(negedge clk);
    mw = {rt, 5'h0, ctl, 20'h0};
    dOut = d;
    repeat (4) @(negedge clk);
  endtask : mc
  task automatic print_verdict;
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    #40000;
    n_fail++;
    print_verdict();
  end
  initial begin
    {rst_b, fd, cf, inh_b, dOut} = {4'h1, 16'h0};
    {frl, frc} = 5'h00;
    mw = {4'hA, 2'h0, 12'hBCD, 30'h0};
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    chk({lds, oe, dIn}, {2'h3, 16'hABCD});
    inh_b = 1'b0;
    @(negedge clk);
    chk(oe, 1'b0);
    inh_b = 1'b1;
    mc(18'h20073, 5'h19, 16'h0);
    chk(lds, 1'b0);
    mc(18'h0, 5'h1A, 16'h9A96);
    chk({ps, flg}, 24'hC0969A);
    chk(fps, 8'h90);
    for (int s = 0; s < 4; s++) begin
      mc(18'h40 | 18'(s << 8), 5'h19, 16'h0);
      e = next_microaddress - 12'h1;
      chk({oe, dIn}, s == 0 ? 17'h1CA90 : s == 1 ? 17'h1C096 : s == 2 ? {2'h2, e, 3'h5} : 17'h10340);
    end
    mc(18'h10040, 5'h19, 16'h0);
    chk(oe, 1'b0);
    e = next_microaddress - 12'h1;
    fd = 1'b1;
    mc(18'h0, 5'h0, 16'h0);
    fd = 1'b0;
    chk(current_microaddress, e);
    repeat (2) mc(18'h0, 5'h0, 16'h0);
    chk(current_microaddress, next_microaddress - 12'h1);
    mc(18'h20000, 5'h19, 16'h0);
    mc(18'h0, 5'h1A, 16'hFFFF);
    chk(ps, 16'hC096);
    {frl, frc} = 5'h1B;
    @(negedge clk);
    frl = 1'b0;
    chk(fps, 8'h9B);
    cf = 1'b1;
    @(negedge clk);
    cf = 1'b0;
    chk({lds, flg}, 9'h190);
    print_verdict();
  end
endmodule : sram_status_access_mux_tb

// [verilog/sram_defines.svh]
// bit positions, selector codes and reset values for the status access mux
`ifndef SRAM_DEFINES_SVH
`define SRAM_DEFINES_SVH
// microword bit positions
`define SRAM_UW_GATE 24
`define SRAM_UW_BOX 23
`define SRAM_UW_STROBE 21
`define SRAM_UW_LOAD 20
// routing register bits (stored at microword bit index - 30)
`define SRAM_RT_FLAGS 0
`define SRAM_RT_PSHI 1
`define SRAM_RT_PROC 6
`define SRAM_RT_RD0 8
`define SRAM_RT_RD1 9
`define SRAM_RT_IO 16
`define SRAM_RT_PSMID 4
`define SRAM_RT_FPS 5
`define SRAM_RT_CC 17
// read selector codes
`define SRAM_RD_FLAGS 2'h0
`define SRAM_RD_PS 2'h1
`define SRAM_RD_CUA 2'h2
`define SRAM_RD_LIT 2'h3
// short-term flag mask: low nibble short, high nibble long
`define SRAM_FLAG_SHORT 8'h0F
`define SRAM_RT_RESET 18'h00000
`define SRAM_PS_RESET 16'h0000
`define SRAM_CUA_RESET 12'h000
`define SRAM_FPS_RESET 8'h00
`define SRAM_FLAG_RESET 8'h00
`define SRAM_NIB_RESET 4'h0
`define SRAM_MODE_RESET 2'h0
`endif

// [verilog/sram_pkg.sv]
// types shared by the status access mux
package sram_pkg;
  typedef logic [15:0] sram_word_t;
  typedef logic [47:0] sram_uword_t;
  typedef logic [17:0] sram_route_t;
  typedef enum logic [1:0] {SRAM_PH_ONE, SRAM_PH_TWO, SRAM_PH_THREE, SRAM_PH_FOUR} sram_phase_t;
endpackage : sram_pkg

// [verilog/sram_status_access_mux.sv]
// status register bank and tri-state read mux onto the input data bus
// Function
// - bus transfer inhibit disables every routing-controlled mux on the input bus.
// - read selector 3 puts the full 16-bit literal on the input bus.
// - literal is microword 47:44 joined with 41:30, gated when both selects high.
// - clear-flags branch clears routing and forces enabled literal selection.
// - current microaddress loads next microaddress at phase three of each microcycle not held by a forced dispatch.
// - forced dispatch freezes current microaddress at the dispatching instruction.
// - selector 2: zero, microaddress, extension flags, fetch overlap indicator.
// - status bit 14 mirrors 15 and 12 mirrors 13; one means user.
// - status 7:4 hold priority and trace, 3:0 the condition codes.
// - select 1 with selector 1 drives the status word onto the bus.
// - select 1 with selector 0 drives fp status low byte on bits 7:0.
// - select 1 with selector 0 also drives flags on upper bits.
// - fp low byte: double, long, truncate, maintenance, then result codes.
// - flags split short and long term; clear-flags clears only short ones.
// - status writes need gate, internal select and strobe all one.
// - status word in three sections enabled by routing bits 47, 34, 31.
// - write loads 3:0 and 7:4 directly, 13:12 from bit 13, 15:14 from 15.
// - condition codes clock at phase two, other sections at phase three.
// - routing bit 35 loads fp low 7:4 at phase two; 3:0 not writable.
// - routing bit 30 loads flags from output bits 15:8 at phase three.
// - selector 0 layout: flag 3, flags 7:4, flags 2:0, fp low byte.
// - selector 1 layout: mode bits doubled, zeros, then status 7:0.
// - routing register loads at phase three when microword bits 24,23,20 set and 21 clear.
`timescale 1ns/1ps
`include "sram_defines.svh"
module sram_status_access_mux (
  input wire logic clk,
  input wire logic rst_b,
  input wire sram_pkg::sram_phase_t phase,
  input wire sram_pkg::sram_uword_t microword,
  input wire logic [11:0] nextMicroaddress,
  input wire logic forcedDispatch,
  input wire logic clearFlags,
  input wire logic busTransferInhibit_b,
  input wire logic [15:0] outputDataBus,
  input wire logic [2:1] extensionFlags,
  input wire logic fetchOverlapIndicator,
  input wire logic [3:0] fpResultCodes,
  input wire logic fpResultLoad,
  output logic [15:0] inputDataBusOut,
  output logic inputDataBusOe,
  output logic [15:0] processorStatusWord,
  output logic [11:0] currentMicroaddress,
  output logic [7:0] fpStatusLow,
  output logic [7:0] flagRegister,
  output logic literalDefaultSelect
);
  import sram_pkg::*;

  sram_route_t route;
  sram_route_t next_route;
  logic literalDefault;
  logic next_literalDefault;
  logic [11:0] next_currentMicroaddress;
  logic dispatchHold;
  logic next_dispatchHold;
  logic [3:0] psCc;
  logic [3:0] next_psCc;
  logic [3:0] psMid;
  logic [3:0] next_psMid;
  logic [1:0] psMode;
  logic [1:0] next_psMode;
  logic [3:0] fpsHi;
  logic [3:0] next_fpsHi;
  logic [3:0] fp_status_low;
  logic [3:0] next_fp_status_low;
  logic [7:0] next_flagRegister;

  // decoded microword and routing controls
  logic writeCycle;
  logic routeLoad;
  logic procSel;
  logic [1:0] readSel;
  sram_word_t literal;

  // the three status words the read mux can pick besides the literal
  sram_word_t flagsWord;
  sram_word_t statusWord;
  sram_word_t addressWord;

  // per-section write strobes, already qualified by phase
  logic wrCc;
  logic wrMid;
  logic wrMode;
  logic wrFps;
  logic wrFlags;

  // one routing bit plus the proc select enables a section
  function automatic logic routeWrite(input sram_route_t r, input int bitPos, input logic wr);
    routeWrite = wr && r[`SRAM_RT_PROC] && r[bitPos];
  endfunction : routeWrite

  // strobe low marks a routing load, strobe high a write
  function automatic logic isRouteLoad(input sram_uword_t uw);
    isRouteLoad = uw[`SRAM_UW_GATE] && uw[`SRAM_UW_BOX] && uw[`SRAM_UW_LOAD] && !uw[`SRAM_UW_STROBE];
  endfunction : isRouteLoad

  // gate bits are shared with memory bus cycles, so all three must be high
  assign writeCycle = microword[`SRAM_UW_GATE] && microword[`SRAM_UW_BOX] && microword[`SRAM_UW_STROBE];
  assign routeLoad = (phase == SRAM_PH_THREE) && isRouteLoad(microword);

  // io bit set hands the input bus to another section
  assign procSel = route[`SRAM_RT_PROC] && !route[`SRAM_RT_IO];
  assign literal = {microword[47:44], microword[41:30]};

  // cleared routing register reads as literal select
  assign readSel = literalDefault ? `SRAM_RD_LIT : {route[`SRAM_RT_RD1], route[`SRAM_RT_RD0]};

  // condition codes and fp bits at phase two, the rest at phase three
  assign wrCc = (phase == SRAM_PH_TWO) && routeWrite(route, `SRAM_RT_CC, writeCycle);
  assign wrFps = (phase == SRAM_PH_TWO) && routeWrite(route, `SRAM_RT_FPS, writeCycle);
  assign wrMid = (phase == SRAM_PH_THREE) && routeWrite(route, `SRAM_RT_PSMID, writeCycle);
  assign wrMode = (phase == SRAM_PH_THREE) && routeWrite(route, `SRAM_RT_PSHI, writeCycle);
  assign wrFlags = (phase == SRAM_PH_THREE) && routeWrite(route, `SRAM_RT_FLAGS, writeCycle);

  // routing register: clear-flags beats a same-cycle load
  // routing holds until the next load, so one setup serves many cycles
  always_comb begin
    next_route = route;
    next_literalDefault = literalDefault;
    if (clearFlags) begin
      next_route = `SRAM_RT_RESET;
      next_literalDefault = 1'b1;
    end else if (routeLoad) begin
      next_route = microword[47:30];
      next_literalDefault = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      route <= `SRAM_RT_RESET;
      literalDefault <= 1'b1;
    end else begin
      route <= next_route;
      literalDefault <= next_literalDefault;
    end
  end

  // microaddress tracking; the hold keeps the dispatching address visible
  // limitation: the first phase three after a dispatch is skipped as well
  always_comb begin
    next_currentMicroaddress = currentMicroaddress;
    next_dispatchHold = dispatchHold;
    if (forcedDispatch) begin
      next_dispatchHold = 1'b1;
    end else if (phase == SRAM_PH_THREE) begin
      next_dispatchHold = 1'b0;
      if (!dispatchHold) begin
        next_currentMicroaddress = nextMicroaddress;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      currentMicroaddress <= `SRAM_CUA_RESET;
      dispatchHold <= 1'b0;
    end else begin
      currentMicroaddress <= next_currentMicroaddress;
      dispatchHold <= next_dispatchHold;
    end
  end

  // condition codes
  always_comb begin
    next_psCc = psCc;
    if (wrCc) begin
      next_psCc = outputDataBus[3:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      psCc <= `SRAM_NIB_RESET;
    end else begin
      psCc <= next_psCc;
    end
  end

  // priority and trace section
  always_comb begin
    next_psMid = psMid;
    if (wrMid) begin
      next_psMid = outputDataBus[7:4];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      psMid <= `SRAM_NIB_RESET;
    end else begin
      psMid <= next_psMid;
    end
  end

  // only two modes exist, so one stored bit per mode field
  always_comb begin
    next_psMode = psMode;
    if (wrMode) begin
      next_psMode = {outputDataBus[15], outputDataBus[13]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      psMode <= `SRAM_MODE_RESET;
    end else begin
      psMode <= next_psMode;
    end
  end

  // fp mode bits: double, long, truncate, maintenance
  always_comb begin
    next_fpsHi = fpsHi;
    if (wrFps) begin
      next_fpsHi = outputDataBus[7:4];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fpsHi <= `SRAM_NIB_RESET;
    end else begin
      fpsHi <= next_fpsHi;
    end
  end

  // result codes come only from the arithmetic side, never the bus
  always_comb begin
    next_fp_status_low = fp_status_low;
    if (fpResultLoad) begin
      next_fp_status_low = fpResultCodes;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fp_status_low <= `SRAM_NIB_RESET;
    end else begin
      fp_status_low <= next_fp_status_low;
    end
  end

  // flags: low nibble short term, high nibble long term
  // clear-flags wins over a same-cycle flag write
  always_comb begin
    next_flagRegister = flagRegister;
    if (wrFlags) begin
      next_flagRegister = outputDataBus[15:8];
    end
    if (clearFlags) begin
      next_flagRegister = flagRegister & ~`SRAM_FLAG_SHORT;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flagRegister <= `SRAM_FLAG_RESET;
    end else begin
      flagRegister <= next_flagRegister;
    end
  end

  // status word: mode bits doubled, nothing stored in 11:8
  assign processorStatusWord = {psMode[1], psMode[1], psMode[0], psMode[0], 4'h0, psMid, psCc};
  assign fpStatusLow = {fpsHi, fp_status_low};
  assign literalDefaultSelect = literalDefault;

  // read words laid out as the datapath expects them
  assign flagsWord = {flagRegister[3], flagRegister[7:4], flagRegister[2:0], fpStatusLow};
  assign statusWord = {processorStatusWord[15:12], 4'h0, processorStatusWord[7:0]};
  assign addressWord = {1'b0, currentMicroaddress, extensionFlags, fetchOverlapIndicator};

  // every selector code is decoded, so no default item
  always_comb begin
    inputDataBusOut = 16'h0000;
    unique case (readSel)
      `SRAM_RD_FLAGS: inputDataBusOut = flagsWord;
      `SRAM_RD_PS: inputDataBusOut = statusWord;
      `SRAM_RD_CUA: inputDataBusOut = addressWord;
      `SRAM_RD_LIT: inputDataBusOut = literal;
    endcase
  end

  // enable off releases the bus to other sources
  // inhibit from bus control overrides both ways of enabling
  assign inputDataBusOe = busTransferInhibit_b && (literalDefault || procSel);

endmodule : sram_status_access_mux
